// [hdl/cit_params.svh]
`ifndef CIT_PARAMS_SVH
`define CIT_PARAMS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CIT_OFF_MODE 8'h00
`define CIT_OFF_COUNT 8'h04
`define CIT_OFF_CAPF 8'h08
`define CIT_OFF_CAPR 8'h0C
`define CIT_OFF_PORT1 8'h10
`define CIT_OFF_PORT2 8'h14
`define CIT_OFF_IRQ 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CIT_OVERFLOW_HIGH_FLAG_BIT 7
`define CIT_OVERFLOW_LOW_FLAG_BIT 6
`define CIT_OVERFLOW_IRQ_ENABLE_BIT 5
`define CIT_IRQ_EDGE_SELECT_BIT 4
`define CIT_CLR_HI_BIT 3
`define CIT_CLR_LO_BIT 2
`define CIT_PIN_SEL_BIT 3
`define CIT_FILT_EN_BIT 4
`define CIT_IRQ_FLAG_BIT 0
`define CIT_IRQ_EN_BIT 1
// ----------------------------------------------------------------
// Reset values, widths and counts
// ----------------------------------------------------------------
`define CIT_MODE_RST 8'h00
`define CIT_COUNT_RST 8'h00
`define CIT_CAP_RST 8'h00
`define CIT_COUNT_MAX 8'hFF
`define CIT_PRESC_W 6
`define CIT_FILT_LEN 5
`define CIT_SYNC_STAGES 2
`define CIT_RESP_OKAY 2'b00
`define CIT_RESP_SLVERR 2'b10
`endif

// [hdl/cit_pkg.sv]
`include "cit_params.svh"
package cit_pkg;
  // Operating state of the surrounding chip
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SLEEP,
    PM_WATCH,
    PM_SUBACTIVE,
    PM_SUBSLEEP,
    PM_STANDBY
  } cit_pwr_t;

  // Registered state of the timer top, apart from the sync and filter chains
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] mode;
    logic [7:0] count;
    logic [7:0] cap_f;
    logic [7:0] cap_r;
    logic pin_sel;
    logic filt_en;
    logic irq_flag;
    logic irq_en;
    logic irq;
    logic [`CIT_PRESC_W-1:0] presc;
    logic wclk_prev;
    logic wdiv;
    logic clk_prev;
    logic cap_prev;
  } cit_state_t;
endpackage

// [hdl/cit_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cit_params.svh"
module cit_sync #(
  parameter int STAGES = `CIT_SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic sync_o
);
  // ----------------------------------------------------------------
  // Flop chain; only the last stage is seen outside
  // ----------------------------------------------------------------
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;

  // Refuse a chain too short to let a metastable first stage settle
  if (STAGES < 2) begin : g_bad_stages
    $error("cit_sync needs at least two stages");
  end

  // Shift toward the output
  always_comb begin
    chain_next = {chain_reg[STAGES-2:0], async_i};
  end

  // Register the chain
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign sync_o = chain_reg[STAGES-1];
endmodule
`default_nettype wire

// [hdl/cit_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cit_params.svh"
module cit_filter #(
  parameter int LEN = `CIT_FILT_LEN
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sample_i,
  input wire logic din_i,
  input wire logic restart_i,
  input wire logic load_i,
  input wire logic load_val_i,
  output logic dout_o,
  output logic fresh_o
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] FULL = CW'(LEN);

  logic [LEN-1:0] stg_reg, stg_next;
  logic dout_reg, dout_next;
  logic [CW-1:0] cnt_reg, cnt_next;

  // Refuse a chain that could not tell a glitch from a level
  if (LEN < 2) begin : g_bad_len
    $error("cit_filter needs at least two latches");
  end

  // ----------------------------------------------------------------
  // Latch chain and agreement check
  // ----------------------------------------------------------------
  // The sample counter tells the top when the chain is not yet full
  always_comb begin
    stg_next = stg_reg;
    dout_next = dout_reg;
    cnt_next = cnt_reg;
    if (load_i) begin
      stg_next = {LEN{load_val_i}};
      dout_next = load_val_i;
      cnt_next = FULL;
    end else if (sample_i) begin
      stg_next = {stg_reg[LEN-2:0], din_i};
      if (cnt_reg < FULL) begin
        cnt_next = cnt_reg + 1'b1;
      end
      if (stg_next == {LEN{stg_next[0]}}) begin
        dout_next = stg_next[0];
      end
    end
    if (restart_i) begin
      cnt_next = '0;
    end
  end

  // Register the filter state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stg_reg <= '0;
      dout_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      stg_reg <= stg_next;
      dout_reg <= dout_next;
      cnt_reg <= cnt_next;
    end
  end

  assign dout_o = dout_reg;
  assign fresh_o = (cnt_reg < FULL);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_filt_agree;
    @(posedge clk_i) disable iff (reset_i)
    $changed(dout_reg) |-> (stg_reg == {LEN{dout_reg}});
  endproperty
  a_filt_agree: assert property (p_filt_agree)
    else $error("filter output moved without agreement");
endmodule
`default_nettype wire

// [hdl/cit_top.sv]
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cit_params.svh"
module cit_top
  import cit_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic capture_pin_i,
  input wire logic watch_clk_i,
  input wire logic [2:0] power_mode_i,
  output logic irq_o
);
  cit_state_t r, n;
  cit_pwr_t pm;
  logic wsync, filt_out, fresh, sel_clk, run, mode_wr_ok;
  logic cap_in, cap_sig, cnt_pulse, samp_pulse, clr;
  logic nat_rise, nat_fall, inj_rise, inj_fall, rise, fall, ovf;
  logic wr_go, wr_hit, wr_mode, wr_port1, wr_port2, wr_irq;
  logic flt_restart, rd_hit;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // Watch clock crossing and capture filter
  // ----------------------------------------------------------------
  // The watch clock is unrelated to clk_i; a count may slip one cycle
  cit_sync #(.STAGES(`CIT_SYNC_STAGES)) u_wsync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(watch_clk_i),
    .sync_o(wsync)
  );

  cit_filter #(.LEN(`CIT_FILT_LEN)) u_filter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sample_i(samp_pulse),
    .din_i(cap_in),
    .restart_i(flt_restart),
    .load_i(inj_rise | inj_fall),
    .load_val_i(inj_rise),
    .dout_o(filt_out),
    .fresh_o(fresh)
  );

  // ----------------------------------------------------------------
  // Clock selection, operating state and capture edges
  // ----------------------------------------------------------------
  always_comb begin
    pm = cit_pwr_t'(power_mode_i);
    mode_wr_ok = (pm == PM_ACTIVE) || (pm == PM_SUBACTIVE);
    // Watch and standby stop count pulses, samples and pin edges; sub modes need watch half
    case (pm)
      PM_ACTIVE, PM_SLEEP: run = 1'b1;
      PM_SUBACTIVE, PM_SUBSLEEP: run = (r.mode[1:0] == 2'b11);
      default: run = 1'b0;
    endcase
    case (r.mode[1:0])
      2'b00: sel_clk = r.presc[5];
      2'b01: sel_clk = r.presc[4];
      2'b10: sel_clk = r.presc[0];
      default: sel_clk = r.wdiv;
    endcase
    // A falling selected level counts, even one made by a switch
    cnt_pulse = run && r.clk_prev && !sel_clk;
    samp_pulse = run && !r.clk_prev && sel_clk;
    cap_in = r.pin_sel && capture_pin_i;
    // Pin select low leaves the input low: plain interval timer
    cap_sig = r.filt_en ? filt_out : cap_in;
    nat_rise = run && cap_sig && !r.cap_prev;
    nat_fall = run && !cap_sig && r.cap_prev;
  end

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_go = r.aw_full && r.w_full && !r.bvalid;
    case (r.awaddr)
      `CIT_OFF_MODE, `CIT_OFF_COUNT, `CIT_OFF_CAPF, `CIT_OFF_CAPR,
      `CIT_OFF_PORT1, `CIT_OFF_PORT2, `CIT_OFF_IRQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    wr_mode = wr_go && r.wstb && (r.awaddr == `CIT_OFF_MODE);
    wr_port1 = wr_go && r.wstb && (r.awaddr == `CIT_OFF_PORT1);
    wr_port2 = wr_go && r.wstb && (r.awaddr == `CIT_OFF_PORT2);
    wr_irq = wr_go && r.wstb && (r.awaddr == `CIT_OFF_IRQ);
    flt_restart = wr_port2 && r.wdata[`CIT_FILT_EN_BIT] && !r.filt_en;
    // Pin select moved while the filter chain is still filling
    inj_rise = 1'b0;
    inj_fall = 1'b0;
    if (wr_port1 && r.filt_en && fresh &&
        (r.wdata[`CIT_PIN_SEL_BIT] != r.pin_sel)) begin
      if (!r.pin_sel) begin
        inj_rise = capture_pin_i;
        inj_fall = !capture_pin_i;
      end else begin
        inj_fall = capture_pin_i;
      end
    end
    // Without the filter the gated input itself makes the false edge
    rise = nat_rise || inj_rise;
    fall = nat_fall || inj_fall;
    case (s_axi_araddr_i)
      `CIT_OFF_MODE: rd_data = {24'h00_0000, r.mode};
      `CIT_OFF_COUNT: rd_data = {24'h00_0000, r.count};
      `CIT_OFF_CAPF: rd_data = {24'h00_0000, r.cap_f};
      `CIT_OFF_CAPR: rd_data = {24'h00_0000, r.cap_r};
      `CIT_OFF_PORT1: rd_data = {28'h000_0000, r.pin_sel, 3'b000};
      `CIT_OFF_PORT2: rd_data = {27'h000_0000, r.filt_en, 4'h0};
      `CIT_OFF_IRQ: rd_data = {30'h0000_0000, r.irq_en, r.irq_flag};
      default: rd_data = 32'h0000_0000;
    endcase
    rd_hit = (s_axi_araddr_i <= `CIT_OFF_IRQ) &&
             (s_axi_araddr_i[1:0] == 2'b00);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    // Address and data are taken in either order, one write at a time
    if (s_axi_awvalid_i && r.awrdy) begin
      n.aw_full = 1'b1;
      n.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && r.wrdy) begin
      n.w_full = 1'b1;
      n.wdata = s_axi_wdata_i[7:0];
      n.wstb = s_axi_wstrb_i[0];
    end
    if (r.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_hit ? `CIT_RESP_OKAY : `CIT_RESP_SLVERR;
    end
    n.awrdy = !n.aw_full;
    n.wrdy = !n.w_full;
    // Read data are captured at acceptance and held until taken
    if (r.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && r.arrdy) begin
      n.rvalid = 1'b1;
      n.rdata = rd_data;
      n.rresp = rd_hit ? `CIT_RESP_OKAY : `CIT_RESP_SLVERR;
    end
    n.arrdy = !n.rvalid;

    // Software writes first, so hardware sets below win over clears
    if (wr_mode && mode_wr_ok) begin
      n.mode[5:0] = r.wdata[5:0];
      if (!r.wdata[`CIT_OVERFLOW_HIGH_FLAG_BIT]) begin
        n.mode[`CIT_OVERFLOW_HIGH_FLAG_BIT] = 1'b0;
      end
      if (!r.wdata[`CIT_OVERFLOW_LOW_FLAG_BIT]) begin
        n.mode[`CIT_OVERFLOW_LOW_FLAG_BIT] = 1'b0;
      end
    end
    if (wr_port1) begin
      n.pin_sel = r.wdata[`CIT_PIN_SEL_BIT];
    end
    if (wr_port2) begin
      n.filt_en = r.wdata[`CIT_FILT_EN_BIT];
    end
    if (wr_irq) begin
      n.irq_en = r.wdata[`CIT_IRQ_EN_BIT];
      if (!r.wdata[`CIT_IRQ_FLAG_BIT]) begin
        n.irq_flag = 1'b0;
      end
    end

    // Divided clocks free-run; watch half toggles on each watch rise
    n.presc = r.presc + 1'b1;
    n.wclk_prev = wsync;
    if (wsync && !r.wclk_prev) begin
      n.wdiv = !r.wdiv;
    end
    n.clk_prev = sel_clk;
    n.cap_prev = (inj_rise || inj_fall) ? inj_rise : cap_sig;

    // Counter clear, capture and overflow
    clr = (rise && r.mode[`CIT_CLR_HI_BIT]) ||
          (fall && r.mode[`CIT_CLR_LO_BIT]);
    ovf = cnt_pulse && !clr && (r.count == `CIT_COUNT_MAX);
    if (clr) begin
      n.count = `CIT_COUNT_RST;
    end else if (cnt_pulse) begin
      n.count = r.count + 1'b1;
    end
    if (rise) begin
      n.cap_r = r.count;
    end
    if (fall) begin
      n.cap_f = r.count;
    end
    if (ovf) begin
      if (r.pin_sel && cap_sig) begin
        n.mode[`CIT_OVERFLOW_HIGH_FLAG_BIT] = 1'b1;
      end else begin
        n.mode[`CIT_OVERFLOW_LOW_FLAG_BIT] = 1'b1;
      end
    end
    if ((ovf && r.mode[`CIT_OVERFLOW_IRQ_ENABLE_BIT]) ||
        (rise && !r.mode[`CIT_IRQ_EDGE_SELECT_BIT]) ||
        (fall && r.mode[`CIT_IRQ_EDGE_SELECT_BIT])) begin
      n.irq_flag = 1'b1;
    end
    n.irq = n.irq_flag && n.irq_en;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.mode <= `CIT_MODE_RST;
      r.count <= `CIT_COUNT_RST;
      r.cap_f <= `CIT_CAP_RST;
      r.cap_r <= `CIT_CAP_RST;
      r.awrdy <= 1'b1;
      r.wrdy <= 1'b1;
      r.arrdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready_o = r.awrdy;
  assign s_axi_wready_o = r.wrdy;
  assign s_axi_bresp_o = r.bresp;
  assign s_axi_bvalid_o = r.bvalid;
  assign s_axi_arready_o = r.arrdy;
  assign s_axi_rdata_o = r.rdata;
  assign s_axi_rresp_o = r.rresp;
  assign s_axi_rvalid_o = r.rvalid;
  assign irq_o = r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_first_count;
    @(posedge clk_i) disable iff (reset_i)
    ($fell(reset_i) && pm == PM_ACTIVE && !wr_go) |->
      ##[60:70] (r.count != `CIT_COUNT_RST);
  endproperty
  a_first_count: assert property (p_first_count)
    else $error("counter did not start after reset");

  property p_ovf_low;
    @(posedge clk_i) disable iff (reset_i)
    (ovf && !r.pin_sel) |=> r.mode[`CIT_OVERFLOW_LOW_FLAG_BIT] &&
      (r.count == `CIT_COUNT_RST);
  endproperty
  a_ovf_low: assert property (p_ovf_low)
    else $error("interval wrap did not set low overflow");

  property p_ovf_irq;
    @(posedge clk_i) disable iff (reset_i)
    (ovf && r.mode[`CIT_OVERFLOW_IRQ_ENABLE_BIT]) |=> r.irq_flag ##0
      (irq_o == r.irq_en);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow request or interrupt wrong");

  property p_fall_count;
    @(posedge clk_i) disable iff (reset_i)
    (cnt_pulse && !clr && r.count != `CIT_COUNT_MAX) |=>
      (r.count == $past(r.count) + 8'h01);
  endproperty
  a_fall_count: assert property (p_fall_count)
    else $error("count pulse did not increment");

  property p_cap_rise;
    @(posedge clk_i) disable iff (reset_i)
    rise |=> (r.cap_r == $past(r.count));
  endproperty
  a_cap_rise: assert property (p_cap_rise)
    else $error("rising capture register not loaded");

  property p_false_rise;
    @(posedge clk_i) disable iff (reset_i)
    (!r.filt_en && run && $rose(r.pin_sel) && capture_pin_i &&
     $past(capture_pin_i)) |-> rise;
  endproperty
  a_false_rise: assert property (p_false_rise)
    else $error("pin select change gave no rising edge");

  property p_standby_hold;
    @(posedge clk_i) disable iff (reset_i)
    (pm == PM_STANDBY) [*2] |-> $stable(r.count) && $stable(r.cap_r)
      && $stable(r.cap_f);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("counter or captures moved in standby");

  property p_clear;
    @(posedge clk_i) disable iff (reset_i)
    (fall && r.mode[`CIT_CLR_LO_BIT]) |=> (r.count == `CIT_COUNT_RST);
  endproperty
  a_clear: assert property (p_clear)
    else $error("falling edge did not clear counter");

  property p_edge_irq;
    @(posedge clk_i) disable iff (reset_i)
    (inj_fall && r.mode[`CIT_IRQ_EDGE_SELECT_BIT]) |=> r.irq_flag;
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("false falling edge did not set request");

  property p_sub_halt;
    @(posedge clk_i) disable iff (reset_i)
    (pm == PM_SUBACTIVE && r.mode[1:0] != 2'b11) |-> !cnt_pulse && !rise;
  endproperty
  a_sub_halt: assert property (p_sub_halt)
    else $error("counter ran in sub mode off watch clock");

  c_overflow: cover property (@(posedge clk_i) disable iff (reset_i) ovf);
  c_capture: cover property (@(posedge clk_i) disable iff (reset_i)
    rise ##[1:1000] fall);
  c_irq: cover property (@(posedge clk_i) disable iff (reset_i)
    $rose(irq_o));
  c_inject: cover property (@(posedge clk_i) disable iff (reset_i)
    inj_rise || inj_fall);
endmodule
`default_nettype wire

// [verification/cit_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Capture source and watch oscillator
// ----------------------------------------
module cit_pin_model (
  input wire logic clk_i,
  input wire logic level_i,
  output logic pin_o,
  output logic watch_clk_o
);
  // Pin moves only after a system edge, as the timer expects a
  // synchronous input; software holds the level it is told to
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    pin_o <= level_i;
  end

  // Free-running watch oscillator, phase unrelated to clk_i
  initial watch_clk_o = 1'b0;
  always #65 watch_clk_o = ~watch_clk_o;
endmodule
`default_nettype wire

// [verification/cit_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cit_params.svh"
module cit_top_tb
  import cit_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, level = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0] pmode = PM_ACTIVE;
  logic awready, wready, bvalid, arready, rvalid, irq, pin, wclk;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, a, b;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  cit_pin_model i_pin (.clk_i(clk_i), .level_i(level), .pin_o(pin),
    .watch_clk_o(wclk));

  cit_top i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .capture_pin_i(pin),
    .watch_clk_i(wclk), .power_mode_i(pmode), .irq_o(irq));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  always #10 clk_i = ~clk_i;
  // Whole run is a few thousand cycles; far above that means a hang
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge clk_i);
    awaddr <= ad;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (awvalid && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_i);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task rc(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] rs;
    rd(ad, d, rs);
    chk(d, exp);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rc(`CIT_OFF_COUNT, 32'h0000_0000);
    rc(`CIT_OFF_MODE, 32'h0000_0000);
    rc(`CIT_OFF_CAPF, 32'h0000_0000);
    rc(`CIT_OFF_CAPR, 32'h0000_0000);
    // Interval wrap at clock over 2 with both enables set
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_MODE, 8'h22, `CIT_RESP_OKAY);
    repeat (600) @(posedge clk_i);
    rc(`CIT_OFF_MODE, 32'h0000_0062);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0001);
    wr(`CIT_OFF_MODE, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    rc(`CIT_OFF_MODE, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    // Width of a 200-cycle high pulse, cleared on both edges
    wr(`CIT_OFF_MODE, 8'h1E, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT1, 8'h08, `CIT_RESP_OKAY);
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    level <= 1'b1;
    repeat (200) @(posedge clk_i);
    level <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`CIT_OFF_CAPF, a, r);
    chk(32'(a >= 97 && a <= 103), 32'h0000_0001);
    rd(`CIT_OFF_COUNT, a, r);
    chk(32'(a < 16), 32'h0000_0001);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    // Pin-function switches with the pin held high
    wr(`CIT_OFF_MODE, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT1, 8'h00, `CIT_RESP_OKAY);
    level <= 1'b1;
    repeat (5) @(posedge clk_i);
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    repeat (5) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0002);
    wr(`CIT_OFF_PORT1, 8'h08, `CIT_RESP_OKAY);
    repeat (5) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_MODE, 8'h12, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT1, 8'h00, `CIT_RESP_OKAY);
    repeat (5) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    level <= 1'b0;
    // Filter on, then pin select set before five samples, pin low
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT2, 8'h10, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT1, 8'h08, `CIT_RESP_OKAY);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    // A two-sample glitch is dropped, a long pulse arrives late
    wr(`CIT_OFF_MODE, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_OFF_IRQ, 8'h02, `CIT_RESP_OKAY);
    level <= 1'b1;
    repeat (4) @(posedge clk_i);
    level <= 1'b0;
    repeat (14) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0002);
    level <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0002);
    repeat (14) @(posedge clk_i);
    rc(`CIT_OFF_IRQ, 32'h0000_0003);
    wr(`CIT_OFF_PORT1, 8'h00, `CIT_RESP_OKAY);
    wr(`CIT_OFF_PORT2, 8'h00, `CIT_RESP_OKAY);
    level <= 1'b0;
    // Unmapped place answers with an error
    wr(8'h1C, 8'h55, `CIT_RESP_SLVERR);
    rd(8'h1C, a, r);
    chk(32'(r), 32'(`CIT_RESP_SLVERR));
    // Low-power states
    wr(`CIT_OFF_MODE, 8'h02, `CIT_RESP_OKAY);
    pmode <= PM_STANDBY;
    rd(`CIT_OFF_COUNT, a, r);
    repeat (50) @(posedge clk_i);
    rc(`CIT_OFF_COUNT, a);
    wr(`CIT_OFF_MODE, 8'h03, `CIT_RESP_OKAY);
    rc(`CIT_OFF_MODE, 32'h0000_0002);
    pmode <= PM_SUBACTIVE;
    rd(`CIT_OFF_COUNT, a, r);
    repeat (50) @(posedge clk_i);
    rc(`CIT_OFF_COUNT, a);
    wr(`CIT_OFF_MODE, 8'h03, `CIT_RESP_OKAY);
    rd(`CIT_OFF_COUNT, a, r);
    repeat (300) @(posedge clk_i);
    rd(`CIT_OFF_COUNT, b, r);
    chk(32'(b != a), 32'h0000_0001);
    pmode <= PM_ACTIVE;
    rd(`CIT_OFF_COUNT, a, r);
    repeat (300) @(posedge clk_i);
    rd(`CIT_OFF_COUNT, b, r);
    chk(32'(b != a), 32'h0000_0001);
    test_done();
  end
endmodule
`default_nettype wire
